/* rtl/asrc_ctrl.sv */
// Host controller that drives an asynchronous 256K x 16 static memory.
`timescale 1ns/10ps
module asrc_ctrl
    import asrc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
)(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_lanes_n,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   chip_select_n,
    output logic                   write_strobe_n,
    output logic                   output_drive_n,
    output logic                   low_byte_sel_n,
    output logic                   high_byte_sel_n,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0]      mem_data_out,
    output logic                   mem_data_oe_n
);
    asrc_state_e       state_q;    // Current bus phase.
    logic [12:0]       settle_q;   // Power-up wait counter.
    logic [1:0]        lanes_q;    // Latched lane selects, active low.
    asrc_tmr_if        tmr ();     // Phase timer handshake.

    // Phase timer shared by read, write and recovery phases.
    asrc_timer u_timer (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .t        (tmr.tmr)
    );

    // Load the timer when entering a timed phase.
    always_comb begin
        tmr.load  = 1'b0;
        tmr.count = '0;
        if (state_q == ASRC_IDLE && req_valid) begin
            tmr.load  = 1'b1;
            // Read needs full access time; write needs float plus setup.
            tmr.count = req_write ? CNT_W'(WRITE_CYC)
                                  : CNT_W'(READ_CYC);
        end else if ((state_q == ASRC_READ || state_q == ASRC_WRITE)
                     && tmr.done) begin
            // Gap lets the device float before the next owner drives.
            tmr.load  = 1'b1;
            tmr.count = CNT_W'(FLOAT_CYC);
        end
    end

    // Power-up wait before the first access is ever started.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_q <= '0;
        end else if (clk_en && state_q == ASRC_POWERUP) begin
            settle_q <= settle_q + 13'h0001;
        end
    end

    // Phase sequencer.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ASRC_POWERUP;
        end else if (clk_en) begin
            unique case (state_q)
                ASRC_POWERUP: begin
                    // Counter is wide enough for the 125-cycle default.
                    if (32'(settle_q) + 1 >= SETTLE_CYCLES) begin
                        state_q <= ASRC_IDLE;
                    end
                end
                ASRC_IDLE: begin
                    if (req_valid) begin
                        state_q <= req_write ? ASRC_WRITE : ASRC_READ;
                    end
                end
                ASRC_READ, ASRC_WRITE: begin
                    if (tmr.done) begin
                        state_q <= ASRC_RECOVER;
                    end
                end
                ASRC_RECOVER: begin
                    if (tmr.done) begin
                        state_q <= ASRC_IDLE;
                    end
                end
            endcase
        end
    end

    // Latch the lanes when a request is taken; the read capture needs
    // them after the request inputs have moved on.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lanes_q <= LANES_OFF;
        end else if (clk_en && state_q == ASRC_IDLE && req_valid) begin
            lanes_q <= req_lanes_n;
        end
    end

    // Address and write data are set in the same edge that starts the
    // access, so both are valid at write start and stay to write end.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr     <= '0;
            mem_data_out <= DATA_ZERO;
        end else if (clk_en && state_q == ASRC_IDLE && req_valid) begin
            mem_addr     <= req_addr;
            mem_data_out <= req_wdata;
        end
    end

    // Pin strobes. Select and write strobe fall together and rise
    // together, so the write ends on one edge and the bus stays floated.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_select_n   <= 1'b1;
            write_strobe_n  <= 1'b1;
            output_drive_n  <= 1'b1;
            low_byte_sel_n  <= 1'b1;
            high_byte_sel_n <= 1'b1;
            mem_data_oe_n   <= 1'b1;
        end else if (clk_en) begin
            if (state_q == ASRC_IDLE && req_valid) begin
                chip_select_n   <= 1'b0;
                write_strobe_n  <= !req_write;
                output_drive_n  <= req_write;
                low_byte_sel_n  <= req_lanes_n[0];
                high_byte_sel_n <= req_lanes_n[1];
                mem_data_oe_n   <= !req_write;
            end else if ((state_q == ASRC_READ || state_q == ASRC_WRITE)
                         && tmr.done) begin
                // Joint rise of select and strobe ends the write.
                chip_select_n   <= 1'b1;
                write_strobe_n  <= 1'b1;
                output_drive_n  <= 1'b1;
                low_byte_sel_n  <= 1'b1;
                high_byte_sel_n <= 1'b1;
                // Data hold after write end is zero, so release at once.
                mem_data_oe_n   <= 1'b1;
            end
        end
    end

    // Capture read data at the end of the access window.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= DATA_ZERO;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            if (state_q == ASRC_READ && tmr.done) begin
                rsp_valid <= 1'b1;
                // Unselected lanes float and read back as zero.
                rsp_rdata <= {lanes_q[1] ? 8'h00 : mem_data_in[15:8],
                              lanes_q[0] ? 8'h00 : mem_data_in[7:0]};
            end
        end
    end

    // Ready flags that the next cycle in idle can take a request.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_ready <= 1'b0;
        end else if (clk_en) begin
            req_ready <= (state_q == ASRC_RECOVER && tmr.done) ||
                         (state_q == ASRC_POWERUP &&
                          32'(settle_q) + 1 >= SETTLE_CYCLES) ||
                         (state_q == ASRC_IDLE && !req_valid);
        end
    end
endmodule

/* rtl/asrc_pkg.sv */
// Package of constants and types for the asynchronous SRAM host controller.
package asrc_pkg;

    // Address and data widths of the memory port.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int WORDS  = 262144;

    // Clock period in picoseconds (125 MHz).
    localparam int CLK_PS = 8000;

    // Documented times, slower grade, in nanoseconds or microseconds.
    localparam int SUPPLY_SETTLE_TIME_US   = 1;
    localparam int ADDR_ACCESS_TIME_NS     = 20;
    localparam int OE_DATA_VALID_NS        = 8;
    localparam int WRITE_DATA_SETUP_NS     = 9;
    localparam int WRITE_PULSE_NS          = 13;
    localparam int STROBE_TO_FLOAT_DELAY_NS = 8;
    localparam int STANDBY_ENTRY_DELAY_NS  = 20;

    // Least times round up to whole cycles.
    localparam int SETTLE_CYC =
        (SUPPLY_SETTLE_TIME_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int READ_CYC =
        (ADDR_ACCESS_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WPULSE_BASE = WRITE_PULSE_NS >
        (STROBE_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS) ?
        WRITE_PULSE_NS : STROBE_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS;
    localparam int WRITE_CYC = (WPULSE_BASE * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FLOAT_CYC =
        (STROBE_TO_FLOAT_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // Width of the shared phase counter.
    localparam int CNT_W = 8;

    // Idle level of the strobes.
    localparam logic [1:0] LANES_OFF = 2'h3;
    localparam logic [15:0] DATA_ZERO = 16'h0000;

    // Controller states.
    typedef enum logic [2:0] {
        ASRC_POWERUP,
        ASRC_IDLE,
        ASRC_READ,
        ASRC_WRITE,
        ASRC_RECOVER
    } asrc_state_e;

endpackage

/* rtl/asrc_timer.sv */
// Phase timer that counts down the length of each bus phase.
`timescale 1ns/10ps
module asrc_timer
    import asrc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    asrc_tmr_if.tmr   t
);
    logic [CNT_W-1:0] left_q; // Cycles still to run.

    // Down counter; done is high once it has reached zero.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= '0;
        end else if (clk_en) begin
            if (t.load) begin
                left_q <= t.count;
            end else if (left_q != '0) begin
                left_q <= left_q - 1'b1;
            end
        end
    end

    // Done looks only at the count. The controller's load decode reads
    // done, so letting done read load again would close a logic loop.
    assign t.done = (left_q == '0);
endmodule

/* rtl/asrc_tmr_if.sv */
// Interface carrying the phase timer handshake inside the controller.
`timescale 1ns/10ps
interface asrc_tmr_if;
    import asrc_pkg::*;
    logic             load;   // Start a new phase.
    logic [CNT_W-1:0] count;  // Cycles the phase lasts, less one.
    logic             done;   // Phase has run out.
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

/* tb/asrc_ctrl_assertions.sv */
// Checker for the pin sequencing of the static memory controller.
`timescale 1ns/10ps
module asrc_ctrl_chk
    import asrc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
)(
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              chip_select_n,
    input wire logic              write_strobe_n,
    input wire logic              output_drive_n,
    input wire logic              low_byte_sel_n,
    input wire logic              high_byte_sel_n,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic              mem_data_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] age_q;  // Cycles since reset, saturating.
    // Never stalls, so it is only a lower bound on the settle wait.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) age_q <= 16'h0000;
        else if (age_q != 16'hffff) age_q <= age_q + 16'h0001;
    end
    settle_wait_a: assert property (
        age_q < SETTLE_CYCLES |-> chip_select_n)
        else $error("access inside the settle period");
    rd_strobe_a: assert property (!output_drive_n |-> write_strobe_n)
        else $error("read with write strobe low");
    no_contend_a: assert property (!output_drive_n |-> mem_data_oe_n)
        else $error("controller drives bus during read");
    wr_select_a: assert property (!write_strobe_n |-> !chip_select_n)
        else $error("write strobe without select");
    wr_pulse_a: assert property ($fell(write_strobe_n) |->
        !write_strobe_n[*4] ##1 write_strobe_n) else $error("bad write pulse");
    wr_end_a: assert property ($rose(write_strobe_n) |->
        $rose(chip_select_n)) else $error("write end not joint");
    wr_data_a: assert property ($rose(write_strobe_n) |->
        !$past(mem_data_oe_n) && $past(mem_data_out) == $past(mem_data_out, 2))
        else $error("write data not held to write end");
    wr_addr_a: assert property ($fell(write_strobe_n) |-> ##1
        $stable({mem_addr, low_byte_sel_n, high_byte_sel_n})[*3])
        else $error("address or lanes moved in write");
endmodule
bind asrc_ctrl asrc_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .core_clk, .reset_n, .mem_addr, .chip_select_n, .write_strobe_n,
    .output_drive_n, .low_byte_sel_n, .high_byte_sel_n, .mem_data_out,
    .mem_data_oe_n);

/* tb/asrc_sram_model.sv */
// Behavioural model of the asynchronous 256K by 16 static memory.
`timescale 1ns/10ps
module asrc_sram_model
    import asrc_pkg::*;
(
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              chip_select_n,
    input  wire logic              write_strobe_n,
    input  wire logic              output_drive_n,
    input  wire logic              low_byte_sel_n,
    input  wire logic              high_byte_sel_n,
    input  wire logic [DATA_W-1:0] bus,
    output logic      [DATA_W-1:0] dev_data
);
    logic [DATA_W-1:0] mem_q [WORDS];
    logic [ADDR_W-1:0] s_addr;         // Address 1 ns ago.
    logic [DATA_W-1:0] s_bus;          // Data lines 1 ns ago.
    logic [1:0]        s_lanes;        // Lane selects 1 ns ago.
    logic [DATA_W-1:0] word;           // Addressed word.
    logic              wr_on;          // Write overlap.
    logic              rd_on;          // Outputs may drive.
    assign wr_on = !chip_select_n && !write_strobe_n;
    assign rd_on = !chip_select_n && !output_drive_n
                   && write_strobe_n;
    // Old copies keep the closing edge clear of the release race.
    assign #1 s_addr = mem_addr;
    assign #1 s_bus = bus;
    assign #1 s_lanes = {high_byte_sel_n, low_byte_sel_n};
    // Whichever strobe rises first ends the write.
    always @(negedge wr_on) begin
        if (!s_lanes[0]) mem_q[s_addr][7:0] = s_bus[7:0];
        if (!s_lanes[1]) mem_q[s_addr][15:8] = s_bus[15:8];
    end
    assign word = mem_q[mem_addr];
    // Floating lanes show the inverted word, so no stale value can match.
    assign #(ADDR_ACCESS_TIME_NS) dev_data = {
        (rd_on && !high_byte_sel_n) ? word[15:8] : ~word[15:8],
        (rd_on && !low_byte_sel_n) ? word[7:0] : ~word[7:0]};
endmodule

/* tb/testbench.sv */
// Self-checking bench for the static memory controller.
`timescale 1ns/10ps
module testbench
    import asrc_pkg::*;
;
    localparam int SET = 4;  // Shortened settle period.
    logic              core_clk, reset_n, clk_en, req_valid, req_write;
    logic              req_ready, rsp_valid, chip_select_n, write_strobe_n;
    logic              output_drive_n, low_byte_sel_n, high_byte_sel_n;
    logic              mem_data_oe_n;
    logic [1:0]        req_lanes_n;
    logic [ADDR_W-1:0] req_addr, mem_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out;
    logic [DATA_W-1:0] dev_data, rd;
    int                fail_count, n_compared;
    asrc_ctrl #(.SETTLE_CYCLES(SET)) dut (.core_clk, .reset_n, .clk_en,
        .req_valid, .req_write, .req_addr, .req_wdata, .req_lanes_n,
        .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_n,
        .write_strobe_n, .output_drive_n, .low_byte_sel_n,
        .high_byte_sel_n, .mem_data_in, .mem_data_out, .mem_data_oe_n);
    asrc_sram_model mem (.mem_addr, .chip_select_n, .write_strobe_n,
        .output_drive_n, .low_byte_sel_n, .high_byte_sel_n,
        .bus(mem_data_in), .dev_data);
    // Whoever drives the lines wins; no pull-ups on this bus.
    assign mem_data_in = mem_data_oe_n ? dev_data : mem_data_out;
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk_w(input logic [DATA_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, exp);
        chk_w({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic give_up;
        fail_count++;
        end_of_test();
    endtask
    // Reset, then watch that nothing starts before the settle time.
    task automatic do_reset;
        int i;
        reset_n = 1'b0;
        repeat (6) tick();
        chk_b(chip_select_n & write_strobe_n & mem_data_oe_n, 1'b1);
        reset_n = 1'b1;
        for (i = 0; req_ready !== 1'b1; i++) begin
            if (i == 40) give_up();
            chk_b(chip_select_n, 1'b1);
            tick();
        end
        chk_b(i >= SET, 1'b1);
    endtask
    // One request held until taken; a read then waits for its answer.
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [1:0] ln);
        int i;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_lanes_n = ln;
        for (i = 0; req_ready !== 1'b1; i++) begin
            if (i == 40) give_up();
            tick();
        end
        tick();
        req_valid = 1'b0;
        // One idle edge keeps back-to-back calls from re-driving valid.
        tick();
        for (i = 0; !w && rsp_valid !== 1'b1; i++) begin
            if (i == 40) give_up();
            tick();
        end
        if (!w) chk_b(i == READ_CYC, 1'b1);
        rd = rsp_rdata;
    endtask
    // Whole words at both ends of the address range.
    task automatic t_word;
        access(1'b1, 18'h0_0000, 16'ha55a, 2'h0);
        access(1'b1, 18'h3_ffff, 16'h1234, 2'h0);
        access(1'b0, 18'h0_0000, 16'h0000, 2'h0);
        chk_w(rd, 16'ha55a);
        access(1'b0, 18'h3_ffff, 16'h0000, 2'h0);
        chk_w(rd, 16'h1234);
    endtask
    // Single-lane writes merge; single-lane reads clear the other byte.
    task automatic t_lanes;
        access(1'b1, 18'h2_0001, 16'h1234, 2'h0);
        access(1'b1, 18'h2_0001, 16'hffcd, 2'h2);
        access(1'b1, 18'h2_0001, 16'hefff, 2'h1);
        access(1'b0, 18'h2_0001, 16'h0000, 2'h0);
        chk_w(rd, 16'hefcd);
        access(1'b0, 18'h2_0001, 16'h0000, 2'h2);
        chk_w(rd, 16'h00cd);
        access(1'b0, 18'h2_0001, 16'h0000, 2'h1);
        chk_w(rd, 16'hef00);
    endtask
    // A low clock enable must leave an offered request untaken.
    task automatic t_freeze;
        int i;
        for (i = 0; req_ready !== 1'b1; i++) begin
            if (i == 40) give_up();
            tick();
        end
        clk_en = 1'b0;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 18'h0_0100;
        req_wdata = 16'h5aa5;
        req_lanes_n = 2'h0;
        repeat (5) begin
            tick();
            chk_b(chip_select_n & write_strobe_n & req_ready, 1'b1);
        end
        clk_en = 1'b1;
        access(1'b1, 18'h0_0100, 16'h5aa5, 2'h0);
        access(1'b0, 18'h0_0100, 16'h0000, 2'h0);
        chk_w(rd, 16'h5aa5);
    endtask
    // A reset in mid-write must drop the strobes and wait again.
    task automatic t_midreset;
        access(1'b1, 18'h1_5555, 16'h0f0f, 2'h0);
        tick();
        do_reset();
        t_word();
    endtask
    task automatic end_of_test;
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        fail_count = 0;
        n_compared = 0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 18'h0_0000;
        req_wdata = 16'h0000;
        req_lanes_n = 2'h3;
        do_reset();
        t_word();
        t_lanes();
        t_freeze();
        t_midreset();
        end_of_test();
    end
endmodule
